// ---- src/pwmoc_top.sv ----
// PWM generator output control and status: status flags, load handshake, time-base capture and
// the pin output path, with registers on an Avalon-MM slave.
// Assumes time base, protection inputs and raw generator outputs arrive synchronous to clk.
// Overview of operation
// - Capture copies count and sets taken flag.
// - Taken flag blocks captures until software clears.
// - Pending load reports one, blocks data writes.
// - Load request sets pending; reads zero.
// - Push-pull phase flag marks second cycle.
// - Center-half flag marks second time-base half.
// - Running flag shows cycle in progress.
// - Invert mode flips outputs under current limit.
// - Swap exchanges high and low pins.
// - Override enables drive pins from override levels.
// - Override timing: cycle start, immediate, load mode.
// - Fault drives pins from fault levels.
// - Limit drives pins from limit levels.
// - Feed-forward drives pins from feed-forward levels.
// - Debug halt drives pins from halt levels.
// - Source select picks capture trigger signal.
// - Writing snapshot bit zero forces capture.
// - Dead-time compensation owner follows select bit.
// - Output mode: complementary, independent, push-pull.
// - Ownership bit hands pin to generator.
// - Polarity bit makes pin active low.
// - Load mode zero loads at cycle start.
// - Start trigger starts cycle; reads zero.
//
// Design decisions made here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pwmoc_params.svh"

module pwmoc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`PWMOC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [15:0] timebase_count,
  input wire logic soc_pulse,
  input wire logic eoc_pulse,
  input wire logic center_mode,
  input wire logic center_second_half,
  input wire logic [2:0] buffer_load_mode,
  input wire pwmoc_pkg::pwmoc_prot_s prot_in,
  input wire pwmoc_pkg::pwmoc_pair_s gen_in,
  output pwmoc_pkg::pwmoc_pair_s pin_out,
  output pwmoc_pkg::pwmoc_pair_s pin_oe,
  output logic data_load,
  output logic data_write_block,
  output logic deadtime_by_feedfwd,
  output logic cycle_running
);
  import pwmoc_pkg::*;

  logic [15:0] io_low;
  logic [15:0] io_high;
  logic [15:0] snapshot;
  logic taken;
  logic pending;
  logic running;
  logic phase;
  logic half;
  logic ack;
  logic [1:0] ovr_live;
  pwmoc_prot_s prot_q;
  logic capture_hw;
  logic do_capture;
  logic bus_req;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wdata;
  logic [15:0] next_wdata_lo;
  logic [15:0] next_wdata_hi;
  logic [31:0] next_readdata;
  logic wr_stat;
  logic sw_capture;
  logic load_now;
  logic ovr_apply;
  pwmoc_mode_e mode;
  pwmoc_override_timing_sel_e override_timing_sel;
  pwmoc_src_e src;
  pwmoc_pair_s shaped;
  pwmoc_pair_s forced;
  pwmoc_pair_s next_pin;

  // Slave answers one cycle after the request so read data come from a register.
  assign bus_req = (avs_read | avs_write) & ~ack;
  assign wdata = avs_writedata[15:0];
  assign wr_lo = avs_write & ~ack & (avs_address == `PWMOC_OFS_IOCTRL_LOW);
  assign wr_hi = avs_write & ~ack & (avs_address == `PWMOC_OFS_IOCTRL_HIGH);
  assign wr_stat = avs_write & ~ack & (avs_address == `PWMOC_OFS_STATUS);
  assign sw_capture = avs_write & ~ack & (avs_address == `PWMOC_OFS_SNAPSHOT) & avs_byteenable[0] & wdata[0];

  always_comb begin
    next_wdata_lo = io_low;
    next_wdata_hi = io_high;
    if (avs_byteenable[0]) begin
      next_wdata_lo[7:0] = wdata[7:0];
      next_wdata_hi[7:0] = wdata[7:0];
    end
    if (avs_byteenable[1]) begin
      next_wdata_lo[15:8] = wdata[15:8];
      next_wdata_hi[15:8] = wdata[15:8];
    end
    next_wdata_hi = next_wdata_hi & `PWMOC_IOH_MASK;
  end

  // Waitrequest idles high and drops for the one cycle after a request has been taken.
  always_ff @(posedge clk) begin
    if (rst) begin
      ack <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack <= bus_req;
      avs_waitrequest <= ~bus_req;
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `PWMOC_OFS_STATUS: begin
        next_readdata[`PWMOC_ST_TAKEN] = taken;
        next_readdata[`PWMOC_ST_PENDING] = pending;
        next_readdata[`PWMOC_ST_PHASE] = phase;
        next_readdata[`PWMOC_ST_HALF] = half;
        next_readdata[`PWMOC_ST_RUN] = running;
      end
      `PWMOC_OFS_IOCTRL_LOW: next_readdata[15:0] = io_low;
      `PWMOC_OFS_IOCTRL_HIGH: next_readdata[15:0] = io_high;
      `PWMOC_OFS_SNAPSHOT: next_readdata[15:0] = snapshot;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_low <= `PWMOC_IOL_RESET;
    end else if (wr_lo) begin
      io_low <= next_wdata_lo;
    end
  end

  // Unimplemented bits are masked on the way in, so they can never read back as one.
  always_ff @(posedge clk) begin
    if (rst) begin
      io_high <= `PWMOC_IOH_RESET;
    end else if (wr_hi) begin
      io_high <= next_wdata_hi;
    end
  end

  // Reserved encodings collapse onto the zero encoding.
  always_comb begin
    case (io_high[`PWMOC_HI_MODE_MSB -: 2])
      2'b01: mode = PWMOC_MODE_INDEP;
      2'b10: mode = PWMOC_MODE_PUSHPULL;
      default: mode = PWMOC_MODE_COMPL;
    endcase
    case (io_low[`PWMOC_LO_OVERRIDE_TIMING_SEL_MSB -: 2])
      2'b01: override_timing_sel = PWMOC_OVERRIDE_TIMING_SEL_NOW;
      2'b10: override_timing_sel = PWMOC_OVERRIDE_TIMING_SEL_UPD;
      default: override_timing_sel = PWMOC_OVERRIDE_TIMING_SEL_SOC;
    endcase
    case (io_high[`PWMOC_HI_SRC_MSB -: 3])
      3'b001: src = PWMOC_SRC_SYNC;
      3'b010: src = PWMOC_SRC_FF;
      3'b011: src = PWMOC_SRC_LIM;
      3'b100: src = PWMOC_SRC_FLT;
      default: src = PWMOC_SRC_SW;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prot_q <= '0;
    end else begin
      prot_q <= prot_in;
    end
  end

  always_comb begin
    case (src)
      PWMOC_SRC_SYNC: capture_hw = prot_in.sync & ~prot_q.sync;
      PWMOC_SRC_FF: capture_hw = prot_in.feedfwd & ~prot_q.feedfwd;
      PWMOC_SRC_LIM: capture_hw = prot_in.limit & ~prot_q.limit;
      PWMOC_SRC_FLT: capture_hw = prot_in.fault & ~prot_q.fault;
      default: capture_hw = 1'b0;
    endcase
  end

  assign do_capture = (capture_hw | sw_capture) & ~taken;

  always_ff @(posedge clk) begin
    if (rst) begin
      snapshot <= 16'h0000;
    end else if (do_capture) begin
      snapshot <= timebase_count;
    end
  end

  // An event that meets the clearing write is dropped, as the flag was still set when it came.
  always_ff @(posedge clk) begin
    if (rst) begin
      taken <= 1'b0;
    end else if (do_capture) begin
      taken <= 1'b1;
    end else if (wr_stat & avs_byteenable[0] & ~wdata[`PWMOC_ST_TAKEN]) begin
      taken <= 1'b0;
    end
  end

  // Only the start-of-cycle load mode is carried here; others load at once.
  assign load_now = pending & ((buffer_load_mode == 3'b000) ? soc_pulse : 1'b1);

  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (wr_stat & avs_byteenable[0] & wdata[`PWMOC_ST_LOADREQ]) begin
      pending <= 1'b1;
    end else if (load_now) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_load <= 1'b0;
    end else begin
      data_load <= load_now;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      data_write_block <= 1'b0;
    end else begin
      data_write_block <= pending;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      running <= 1'b0;
    end else if (wr_stat & avs_byteenable[0] & wdata[`PWMOC_ST_START]) begin
      running <= 1'b1;
    end else if ((wr_stat & avs_byteenable[0] & wdata[`PWMOC_ST_STOP]) | eoc_pulse) begin
      running <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= 1'b0;
    end else if (mode != PWMOC_MODE_PUSHPULL) begin
      phase <= 1'b0;
    end else if (running & soc_pulse) begin
      phase <= ~phase;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      half <= 1'b0;
    end else begin
      half <= center_mode & center_second_half;
    end
  end

  // Override settings are shadowed so the selected timing decides when they reach the pins.
  assign ovr_apply = (override_timing_sel == PWMOC_OVERRIDE_TIMING_SEL_NOW) | ((override_timing_sel == PWMOC_OVERRIDE_TIMING_SEL_SOC) & soc_pulse)
    | ((override_timing_sel == PWMOC_OVERRIDE_TIMING_SEL_UPD) & load_now);

  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_live <= 2'b00;
    end else if (ovr_apply) begin
      ovr_live <= {io_low[`PWMOC_LO_OVR_H], io_low[`PWMOC_LO_OVR_L]};
    end
  end

  logic [1:0] ovr_dat;
  always_ff @(posedge clk) begin
    if (rst) begin
      ovr_dat <= 2'b00;
    end else if (ovr_apply) begin
      ovr_dat <= io_low[`PWMOC_LO_OVERRIDE_LEVELS_MSB -: 2];
    end
  end

  always_comb begin
    case (mode)
      PWMOC_MODE_INDEP: shaped = gen_in;
      PWMOC_MODE_PUSHPULL: shaped = phase ? '{high: 1'b0, low: gen_in.high} : '{high: gen_in.high, low: 1'b0};
      default: shaped = '{high: gen_in.high, low: ~gen_in.high};
    endcase
  end

  always_comb begin
    forced = shaped;
    if (ovr_live[1]) begin
      forced.high = ovr_dat[1];
    end
    if (ovr_live[0]) begin
      forced.low = ovr_dat[0];
    end
    if (prot_in.halt) begin
      forced = io_low[`PWMOC_LO_HALT_MSB -: 2];
    end
    if (prot_in.feedfwd) begin
      forced = io_low[`PWMOC_LO_FF_MSB -: 2];
    end
    if (prot_in.limit) begin
      if (io_low[`PWMOC_LO_INVMODE]) begin
        forced = ~forced;
      end else begin
        forced = io_low[`PWMOC_LO_LIM_MSB -: 2];
      end
    end
    if (prot_in.fault) begin
      forced = io_low[`PWMOC_LO_FLT_MSB -: 2];
    end
    // Polarity then swap are applied last so forced levels are logical, not electrical.
    next_pin.high = forced.high ^ io_high[`PWMOC_HI_POL_H];
    next_pin.low = forced.low ^ io_high[`PWMOC_HI_POL_L];
    if (io_low[`PWMOC_LO_SWAP]) begin
      next_pin = '{high: next_pin.low, low: next_pin.high};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out <= '0;
    end else begin
      pin_out <= next_pin;
    end
  end

  // Ownership shares the pin register delay, so a pin is never handed over mid-level.
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= '{high: io_high[`PWMOC_HI_OWN_H], low: io_high[`PWMOC_HI_OWN_L]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      deadtime_by_feedfwd <= 1'b0;
    end else begin
      deadtime_by_feedfwd <= io_high[`PWMOC_HI_DTSEL];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cycle_running <= 1'b0;
    end else begin
      cycle_running <= running;
    end
  end

endmodule
`default_nettype wire

// ---- src/pwmoc_params.svh ----
// Register offsets, field positions and reset values for the PWM output control block.
// Included by the package and the design; holds definitions only.
`ifndef PWMOC_PARAMS_SVH
`define PWMOC_PARAMS_SVH

`define PWMOC_ADDR_W 4
`define PWMOC_OFS_STATUS 4'h0
`define PWMOC_OFS_IOCTRL_LOW 4'h4
`define PWMOC_OFS_IOCTRL_HIGH 4'h8
`define PWMOC_OFS_SNAPSHOT 4'hc

`define PWMOC_ST_RUN 0
`define PWMOC_ST_HALF 1
`define PWMOC_ST_PHASE 2
`define PWMOC_ST_LOADREQ 3
`define PWMOC_ST_PENDING 4
`define PWMOC_ST_TAKEN 5
`define PWMOC_ST_STOP 6
`define PWMOC_ST_START 7

`define PWMOC_IOL_RESET 16'h0000
`define PWMOC_IOH_RESET 16'h0000
`define PWMOC_IOH_MASK 16'h713f

`define PWMOC_LO_INVMODE 15
`define PWMOC_LO_SWAP 14
`define PWMOC_LO_OVR_H 13
`define PWMOC_LO_OVR_L 12
`define PWMOC_LO_OVERRIDE_LEVELS_MSB 11
`define PWMOC_LO_OVERRIDE_TIMING_SEL_MSB 9
`define PWMOC_LO_FLT_MSB 7
`define PWMOC_LO_LIM_MSB 5
`define PWMOC_LO_FF_MSB 3
`define PWMOC_LO_HALT_MSB 1

`define PWMOC_HI_SRC_MSB 14
`define PWMOC_HI_DTSEL 8
`define PWMOC_HI_MODE_MSB 5
`define PWMOC_HI_OWN_H 3
`define PWMOC_HI_OWN_L 2
`define PWMOC_HI_POL_H 1
`define PWMOC_HI_POL_L 0

`endif

// ---- src/pwmoc_pkg.sv ----
// Types shared by the PWM output control block.
// Assumes the constants header sits beside it.
`include "pwmoc_params.svh"

package pwmoc_pkg;

  typedef enum logic [1:0] {
    PWMOC_MODE_COMPL = 2'b00,
    PWMOC_MODE_INDEP = 2'b01,
    PWMOC_MODE_PUSHPULL = 2'b10
  } pwmoc_mode_e;

  typedef enum logic [1:0] {
    PWMOC_OVERRIDE_TIMING_SEL_SOC = 2'b00,
    PWMOC_OVERRIDE_TIMING_SEL_NOW = 2'b01,
    PWMOC_OVERRIDE_TIMING_SEL_UPD = 2'b10
  } pwmoc_override_timing_sel_e;

  typedef enum logic [2:0] {
    PWMOC_SRC_SW = 3'b000,
    PWMOC_SRC_SYNC = 3'b001,
    PWMOC_SRC_FF = 3'b010,
    PWMOC_SRC_LIM = 3'b011,
    PWMOC_SRC_FLT = 3'b100
  } pwmoc_src_e;

  typedef struct packed {
    logic fault;
    logic limit;
    logic feedfwd;
    logic sync;
    logic halt;
  } pwmoc_prot_s;

  typedef struct packed {
    logic high;
    logic low;
  } pwmoc_pair_s;

endpackage

// ---- testbench/pwmoc_props.sv ----
// Checker for the PWM output control block: bus answer, pin path and status outputs.
// Bound to pwmoc_top and sees only its ports; register copies follow committed writes.
`timescale 1ns/1ns
`default_nettype none
`include "pwmoc_params.svh"
module pwmoc_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`PWMOC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic soc_pulse,
  input wire logic eoc_pulse,
  input wire logic [2:0] buffer_load_mode,
  input wire pwmoc_pkg::pwmoc_prot_s prot_in,
  input wire pwmoc_pkg::pwmoc_pair_s pin_out,
  input wire pwmoc_pkg::pwmoc_pair_s pin_oe,
  input wire logic data_load,
  input wire logic data_write_block,
  input wire logic deadtime_by_feedfwd,
  input wire logic cycle_running
);
  import pwmoc_pkg::*;
  logic [15:0] lo;
  logic [15:0] hi;
  logic hit;
  assign hit = avs_write && avs_waitrequest;
  function automatic logic [1:0] mapf(input logic [1:0] v, input logic [1:0] pol, input logic sw);
    logic [1:0] p;
    begin
      p = v ^ pol;
      mapf = sw ? {p[0], p[1]} : p;
    end
  endfunction
  // Copies follow committed writes only, so a held request is counted once.
  always_ff @(posedge clk) begin
    if (rst) lo <= 16'h0000;
    else if (hit && avs_address == `PWMOC_OFS_IOCTRL_LOW) lo <= avs_writedata[15:0];
  end
  always_ff @(posedge clk) begin
    if (rst) hi <= 16'h0000;
    else if (hit && avs_address == `PWMOC_OFS_IOCTRL_HIGH) hi <= avs_writedata[15:0] & `PWMOC_IOH_MASK;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start;
    hit && avs_address == `PWMOC_OFS_STATUS && avs_writedata[7] && !avs_writedata[6] && !eoc_pulse;
  endsequence
  sequence s_req;
    hit && avs_address == `PWMOC_OFS_STATUS && avs_writedata[3];
  endsequence
  property p_wait; avs_waitrequest && (avs_read || avs_write) |=> !avs_waitrequest; endproperty
  property p_flt; prot_in.fault |=> pin_out == $past(mapf(lo[7:6], hi[1:0], lo[14])); endproperty
  property p_lim;
    !prot_in.fault && prot_in.limit && !lo[15] |=> pin_out == $past(mapf(lo[5:4], hi[1:0], lo[14]));
  endproperty
  property p_ff;
    prot_in[4:2] == 3'b001 |=> pin_out == $past(mapf(lo[3:2], hi[1:0], lo[14]));
  endproperty
  property p_halt;
    prot_in[4:2] == 3'b000 && prot_in.halt |=> pin_out == $past(mapf(lo[1:0], hi[1:0], lo[14]));
  endproperty
  property p_oe; hi == $past(hi) |-> pin_oe == hi[3:2]; endproperty
  property p_dt; hi == $past(hi) |-> deadtime_by_feedfwd == hi[8]; endproperty
  property p_start; s_start ##1 !eoc_pulse |-> ##[0:1] cycle_running; endproperty
  property p_stop; eoc_pulse && !avs_write |-> ##2 !cycle_running; endproperty
  property p_pend; s_req |-> ##[1:3] data_write_block; endproperty
  property p_load;
    data_load && $past(buffer_load_mode) == 3'b000 |-> $past(soc_pulse);
  endproperty
  a_wait: assert property (p_wait) else $error("waitrequest held past one cycle");
  a_flt: assert property (p_flt) else $error("fault levels not on pins");
  a_lim: assert property (p_lim) else $error("limit levels not on pins");
  a_ff: assert property (p_ff) else $error("feed-forward levels not on pins");
  a_halt: assert property (p_halt) else $error("halt levels not on pins");
  a_oe: assert property (p_oe) else $error("pin ownership mismatch");
  a_dt: assert property (p_dt) else $error("dead-time owner mismatch");
  a_start: assert property (p_start) else $error("start did not set running");
  a_stop: assert property (p_stop) else $error("end of cycle left running set");
  a_pend: assert property (p_pend) else $error("load request not pending");
  a_load: assert property (p_load) else $error("load outside start of cycle");
endmodule
bind pwmoc_top pwmoc_props pwmoc_props_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .soc_pulse(soc_pulse), .eoc_pulse(eoc_pulse),
  .buffer_load_mode(buffer_load_mode), .prot_in(prot_in), .pin_out(pin_out), .pin_oe(pin_oe),
  .data_load(data_load), .data_write_block(data_write_block), .deadtime_by_feedfwd(deadtime_by_feedfwd),
  .cycle_running(cycle_running));
`default_nettype wire

// ---- testbench/pwmoc_stage.sv ----
// Power stage model: the levels the gate drivers see on the high and low pins.
// Assumes the driver inputs carry pull-downs, so an unowned pin reads low.
`timescale 1ns/1ns
`default_nettype none
module pwmoc_stage (
  input wire pwmoc_pkg::pwmoc_pair_s pin_out,
  input wire pwmoc_pkg::pwmoc_pair_s pin_oe,
  output logic seen_high,
  output logic seen_low
);
  import pwmoc_pkg::*;
  assign seen_high = pin_oe.high ? pin_out.high : 1'b0;
  assign seen_low = pin_oe.low ? pin_out.low : 1'b0;
endmodule
`default_nettype wire

// ---- testbench/pwm_output_control_status_tb_top.sv ----
// Self-checking bench for the PWM output control block.
// Assumes the design, package and checker are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module pwm_output_control_status_tb_top;
  import pwmoc_pkg::*;
  logic clk = 0, rst = 1, rd = 0, wr = 0, soc = 0, eoc = 0, cm = 0, csh = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [15:0] cnt = 16'h0000, q;
  logic [2:0] blm = 3'h0;
  pwmoc_prot_s prot = 5'h00;
  pwmoc_pair_s gen = 2'h0, po, oe;
  logic [31:0] rdata;
  logic ws, dl, dwb, dtc, run, sh, sl;
  int errors = 0, checks_done = 0;
  always #10 clk = ~clk;
  pwmoc_top pwmoc_top_inst (.clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(ws),
    .timebase_count(cnt), .soc_pulse(soc), .eoc_pulse(eoc), .center_mode(cm), .center_second_half(csh),
    .buffer_load_mode(blm), .prot_in(prot), .gen_in(gen), .pin_out(po), .pin_oe(oe), .data_load(dl),
    .data_write_block(dwb), .deadtime_by_feedfwd(dtc), .cycle_running(run));
  pwmoc_stage pwmoc_stage_inst (.pin_out(po), .pin_oe(oe), .seen_high(sh), .seen_low(sl));
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Waitrequest and read data come from flops, so right after an edge they still show what the edge before it loaded.
  task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= {16'h0000, d};
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (ws !== 1'b0 && n < 50);
    if (n >= 50) errors++;
    q = rdata[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask
  task rc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    bus(0, a, 16'h0000);
    `CHK(q & m, e)
  endtask
  task pulse_soc;
    soc <= 1'b1;
    @(posedge clk);
    soc <= 1'b0;
  endtask
  task t_regs;
    rc(4'h4, 16'hffff, 16'h0000);
    rc(4'h8, 16'hffff, 16'h0000);
    bus(1, 4'h8, 16'hffff);
    rc(4'h8, 16'hffff, 16'h713f);
    `CHK(dtc, 1'b1)
    bus(1, 4'h8, 16'h0000);
    `CHK(dtc, 1'b0)
    bus(1, 4'h4, 16'ha5c3);
    rc(4'h4, 16'hffff, 16'ha5c3);
    rc(4'h2, 16'hffff, 16'h0000);
    bus(1, 4'h4, 16'h0000);
  endtask
  task t_run;
    cm <= 1'b1;
    csh <= 1'b1;
    bus(1, 4'h0, 16'h0080);
    rc(4'h0, 16'h0083, 16'h0003);
    `CHK(run, 1'b1)
    bus(1, 4'h0, 16'h0040);
    rc(4'h0, 16'h00c1, 16'h0000);
    `CHK(run, 1'b0)
    bus(1, 4'h0, 16'h0080);
    eoc <= 1'b1;
    @(posedge clk);
    eoc <= 1'b0;
    rc(4'h0, 16'h0001, 16'h0000);
    cm <= 1'b0;
  endtask
  task t_load;
    bus(1, 4'h0, 16'h0008);
    rc(4'h0, 16'h0018, 16'h0010);
    `CHK(dwb, 1'b1)
    pulse_soc;
    @(posedge clk);
    `CHK(dl, 1'b1)
    repeat (2) @(posedge clk);
    rc(4'h0, 16'h0010, 16'h0000);
  endtask
  task t_pp;
    gen <= 2'b10;
    bus(1, 4'h8, 16'h002c);
    bus(1, 4'h0, 16'h0080);
    rc(4'h0, 16'h0004, 16'h0000);
    `CHK({sh, sl}, 2'b10)
    pulse_soc;
    rc(4'h0, 16'h0004, 16'h0004);
    `CHK({sh, sl}, 2'b01)
    bus(1, 4'h8, 16'h0000);
  endtask
  task t_cap;
    int i;
    cnt <= 16'h1234;
    bus(1, 4'hc, 16'h0001);
    rc(4'hc, 16'hffff, 16'h1234);
    rc(4'h0, 16'h0020, 16'h0020);
    cnt <= 16'h4321;
    bus(1, 4'hc, 16'h0001);
    rc(4'hc, 16'hffff, 16'h1234);
    for (i = 1; i <= 5; i++) begin
      bus(1, 4'h0, 16'h0000);
      bus(1, 4'h8, (i < 5) ? 16'(i << 12) : 16'h0000);
      cnt <= 16'h1000 + 16'(i);
      prot <= (i < 5) ? 5'(1 << i) : 5'h10;
      @(posedge clk);
      prot <= 5'h00;
      rc(4'hc, 16'hffff, 16'h1000 + 16'((i < 5) ? i : 4));
    end
  endtask
  task pin_case(input logic [4:0] p, input logic [15:0] l, input logic [15:0] h, input logic [1:0] g,
                input logic [1:0] e);
    prot <= p;
    gen <= g;
    bus(1, 4'h4, l);
    bus(1, 4'h8, h);
    `CHK({sh, sl}, e)
  endtask
  task t_pins;
    pin_case(5'h10, 16'h0080, 16'h000c, 2'b00, 2'b10);
    pin_case(5'h10, 16'h0080, 16'h000d, 2'b00, 2'b11);
    pin_case(5'h10, 16'h4080, 16'h000c, 2'b00, 2'b01);
    pin_case(5'h18, 16'h0030, 16'h000c, 2'b00, 2'b00);
    pin_case(5'h08, 16'h0020, 16'h000c, 2'b00, 2'b10);
    pin_case(5'h08, 16'h8000, 16'h001c, 2'b10, 2'b01);
    pin_case(5'h04, 16'h0004, 16'h000c, 2'b00, 2'b01);
    pin_case(5'h01, 16'h0002, 16'h000c, 2'b00, 2'b10);
    pin_case(5'h10, 16'h00c0, 16'h0008, 2'b00, 2'b10);
    pin_case(5'h00, 16'h0000, 16'h001c, 2'b10, 2'b10);
    pin_case(5'h00, 16'h0000, 16'h000c, 2'b00, 2'b01);
    pin_case(5'h00, 16'h3900, 16'h000c, 2'b00, 2'b10);
    pin_case(5'h00, 16'h3400, 16'h000c, 2'b00, 2'b10);
    pulse_soc;
    repeat (2) @(posedge clk);
    `CHK({sh, sl}, 2'b01)
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_run;
    t_load;
    t_pp;
    t_cap;
    t_pins;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
